/* src/rdwdt_pkg.sv */
package rdwdt_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] RDWDT_MODE_OFS = 8'h00;
    localparam logic [7:0] RDWDT_CLEAR_OFS = 8'h04;
    localparam logic [7:0] RDWDT_STATUS_OFS = 8'h08;
    localparam logic [7:0] RDWDT_MASK_OFS = 8'h0C;
    localparam logic [7:0] RDWDT_COUNT_OFS = 8'h10;

    // Mode register field positions
    localparam int RDWDT_DIS_POS = 7;
    localparam int RDWDT_PER_POS = 5;
    localparam int RDWDT_ACT_POS = 1;

    // Reset values
    localparam logic [7:0] RDWDT_MODE_RST = 8'h82;
    localparam logic [1:0] RDWDT_PER_RST = 2'h0;
    localparam logic [7:0] RDWDT_MASK_RST = 8'h00;
    localparam logic [7:0] RDWDT_STATUS_RST = 8'h00;

    // Clear key and status bit positions
    localparam logic [7:0] RDWDT_CLEAR_KEY = 8'h4E;
    localparam int RDWDT_ST_EXPIRY = 0;
    localparam int RDWDT_ST_CLEARED = 1;

    // Counter geometry; taps count half-rate ticks
    localparam int RDWDT_CNT_W = 20;
    localparam int RDWDT_TAP0 = 15;
    localparam int RDWDT_TAP1 = 17;
    localparam int RDWDT_TAP2 = 19;

    // Bus responses
    localparam logic [1:0] RDWDT_RESP_OKAY = 2'h0;
    localparam logic [1:0] RDWDT_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RDWDT_PER_16 = 2'b00,
        RDWDT_PER_18 = 2'b01,
        RDWDT_PER_20 = 2'b10,
        RDWDT_PER_22 = 2'b11
    } rdwdt_period_t;

    typedef struct packed {
        logic wd_disable_bit;
        rdwdt_period_t detect_period_sel;
        logic expiry_action_sel;
    } rdwdt_mode_t;

    // Processor power and clock state, as seen by the watchdog
    typedef struct packed {
        logic stop_mode;
        logic idle_level_one;
        logic warmup_active;
        logic hs_switch;
        logic standby_exit;
    } rdwdt_power_t;

endpackage : rdwdt_pkg

/* src/rdwdt_top.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Twenty-stage up-counter advances once every two CPU clocks.
// - Two-bit period field resets to 00, giving 2^16 CPU clocks.
// - Disable bit resets to 1; clearing it to 0 enables the watchdog.
// - Once enabled, writes cannot disable it; only reset does.
// - Action bit resets to 1 for interrupt; 0 selects hardware reset.
// - Once reset action chosen, interrupt action returns only through reset.
// - Writing 4E to the clear register zeroes the counter.
// - Selected tap overflow raises interrupt or reset per the action bit.
// - Expiry interrupt goes to the CPU as a non-maskable interrupt.
// - Idle after reset; counting starts only once enabled by software.
// - Counter halts in stop and idle-one; resumes after warm-up ends.
// - Counter runs normally in run mode.
// - Counter cleared on low-to-high clock switch and on standby exit.
module rdwdt_top
    import rdwdt_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Processor power and clock state
    input wire rdwdt_pkg::rdwdt_power_t power_state,
    // Toward the CPU core
    output logic wd_expiry_irq,
    output logic hw_reset_req,
    output logic irq
);
    import rdwdt_pkg::*;

    // Carry out of the selected tap on this tick; fires once per period,
    // so an unserviced timer keeps expiring every period
    function automatic logic tap_hit(input logic [RDWDT_CNT_W-1:0] cnt, input rdwdt_period_t sel,
                                     input logic wrapped);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            // 2^15 ticks of the half-rate clock
            RDWDT_PER_16: hit = &cnt[RDWDT_TAP0-1:0];
            // 2^17 ticks
            RDWDT_PER_18: hit = &cnt[RDWDT_TAP1-1:0];
            // 2^19 ticks
            RDWDT_PER_20: hit = &cnt[RDWDT_TAP2-1:0];
            // 2^21 ticks: the wrap flag acts as a twenty-first stage
            RDWDT_PER_22: hit = &cnt & wrapped;
        endcase
        return hit;
    endfunction : tap_hit

    // Address decode shared by reads and writes
    function automatic logic ofs_mapped(input logic [7:0] a);
        return (a == RDWDT_MODE_OFS) || (a == RDWDT_CLEAR_OFS) || (a == RDWDT_STATUS_OFS) ||
               (a == RDWDT_MASK_OFS) || (a == RDWDT_COUNT_OFS);
    endfunction : ofs_mapped

    // Register state
    rdwdt_mode_t mode;
    logic [7:0] status;
    logic [7:0] mask;
    logic [RDWDT_CNT_W-1:0] count;
    logic wrapped;
    logic half_phase;
    logic reset_latched;

    // Bus state
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic [1:0] bresp;
    logic bvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;

    // Write decode
    wire do_write = aw_held & w_held & ~bvalid;
    wire low_lane = w_strb[0];
    wire [7:0] wbyte = w_data[7:0];
    wire wr_mode = do_write & low_lane & (aw_addr == RDWDT_MODE_OFS);
    wire wr_clear = do_write & low_lane & (aw_addr == RDWDT_CLEAR_OFS);
    wire wr_status = do_write & low_lane & (aw_addr == RDWDT_STATUS_OFS);
    wire wr_mask = do_write & low_lane & (aw_addr == RDWDT_MASK_OFS);
    wire key_ok = wr_clear & (wbyte == RDWDT_CLEAR_KEY);

    // Sticky bits only move toward enabled and toward reset action
    wire next_disable = mode.wd_disable_bit & wbyte[RDWDT_DIS_POS];
    wire next_action = mode.expiry_action_sel & wbyte[RDWDT_ACT_POS];
    wire [1:0] next_period = wbyte[RDWDT_PER_POS+1:RDWDT_PER_POS];

    // Power state decode
    wire in_stop = power_state.stop_mode;
    wire in_idle_one = power_state.idle_level_one;
    wire warming_up = power_state.warmup_active;
    wire clk_to_fast = power_state.hs_switch;
    wire leaving_standby = power_state.standby_exit;

    // Counter control
    wire enabled = ~mode.wd_disable_bit;
    wire halted = in_stop | in_idle_one | warming_up;
    // Shared with the warm-up timer, so clock and standby changes restart it
    wire clear_cnt = key_ok | clk_to_fast | leaving_standby;
    wire tick = enabled & ~halted & half_phase;
    wire expire = tick & ~clear_cnt & tap_hit(count, mode.detect_period_sel, wrapped);
    wire expire_irq = expire & mode.expiry_action_sel;
    wire expire_rst = expire & ~mode.expiry_action_sel;

    // Status events; set wins over a same-cycle clear
    wire [7:0] events = ({7'h00, expire} << RDWDT_ST_EXPIRY) | ({7'h00, key_ok} << RDWDT_ST_CLEARED);
    wire [7:0] clr_bits = wr_status ? wbyte : 8'h00;
    wire [7:0] next_status = (status & ~clr_bits) | events;

    // Read decode
    wire rd_take = s_axi_arvalid & ~rvalid;
    wire rd_is_mode = (s_axi_araddr == RDWDT_MODE_OFS);
    wire rd_is_status = (s_axi_araddr == RDWDT_STATUS_OFS);
    wire rd_is_mask = (s_axi_araddr == RDWDT_MASK_OFS);
    wire rd_is_count = (s_axi_araddr == RDWDT_COUNT_OFS);
    wire [31:0] mode_word = {24'h000000, mode.wd_disable_bit, mode.detect_period_sel, 3'h0,
                             mode.expiry_action_sel, 1'b0};
    wire [31:0] status_word = {24'h000000, status};
    wire [31:0] mask_word = {24'h000000, mask};
    wire [31:0] count_word = {12'h000, count};
    // Clear key reads as zero so software cannot learn it back
    wire [31:0] next_rdata = ({32{rd_is_mode}} & mode_word) |
                             ({32{rd_is_status}} & status_word) |
                             ({32{rd_is_mask}} & mask_word) |
                             ({32{rd_is_count}} & count_word);
    wire [1:0] next_rresp = ofs_mapped(s_axi_araddr) ? RDWDT_RESP_OKAY : RDWDT_RESP_SLVERR;
    wire [1:0] next_bresp = ofs_mapped(aw_addr) ? RDWDT_RESP_OKAY : RDWDT_RESP_SLVERR;

    // Handshake outputs
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready = ~w_held;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_arready = ~rvalid;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign irq = |(status & mask);

    // Write address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
        end else if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // Address only loads while the slot is free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && !aw_held) begin
            aw_addr <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
        end else if (do_write) begin
            bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            bvalid <= 1'b0;
        end
    end

    // Response code stands with bvalid until accepted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp <= RDWDT_RESP_OKAY;
        end else if (do_write) begin
            bresp <= next_bresp;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
        end else if (rd_take) begin
            rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            rvalid <= 1'b0;
        end
    end

    // Read data is a snapshot taken with the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata <= 32'h00000000;
            rresp <= RDWDT_RESP_OKAY;
        end else if (rd_take) begin
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // Mode register; period may change at any time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode.wd_disable_bit <= RDWDT_MODE_RST[RDWDT_DIS_POS];
            mode.detect_period_sel <= rdwdt_period_t'(RDWDT_PER_RST);
            mode.expiry_action_sel <= RDWDT_MODE_RST[RDWDT_ACT_POS];
        end else if (wr_mode) begin
            mode.wd_disable_bit <= next_disable;
            mode.detect_period_sel <= rdwdt_period_t'(next_period);
            mode.expiry_action_sel <= next_action;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask <= RDWDT_MASK_RST;
        end else if (wr_mask) begin
            mask <= wbyte;
        end
    end

    // Set wins over a same-cycle write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= RDWDT_STATUS_RST;
        end else begin
            status <= next_status;
        end
    end

    // Half-rate phase; frozen while disabled so the first tick is deterministic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_phase <= 1'b0;
        end else begin
            half_phase <= enabled & ~halted & ~half_phase;
        end
    end

    // The long setting needs one stage beyond the twenty, held as a wrap flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            wrapped <= 1'b0;
        end else if (clear_cnt) begin
            count <= '0;
            wrapped <= 1'b0;
        end else if (tick) begin
            count <= count + 1'b1;
            wrapped <= wrapped ^ (&count);
        end
    end

    // One-cycle pulse; the core takes it as non-maskable, mask only gates irq
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_expiry_irq <= 1'b0;
        end else begin
            wd_expiry_irq <= expire_irq;
        end
    end

    // Reset request latches; no register write can withdraw it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_latched <= 1'b0;
        end else begin
            reset_latched <= reset_latched | expire_rst;
        end
    end

    // Held until the system reset it causes comes back around
    assign hw_reset_req = reset_latched;

endmodule : rdwdt_top

/* tb/rdwdt_assertions.sv */
`timescale 1ns/1ns
module rdwdt_chk
    import rdwdt_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus answers
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power state and CPU side
    input wire rdwdt_pkg::rdwdt_power_t power_state,
    input wire logic wd_expiry_irq,
    input wire logic hw_reset_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [16:0] since_rst;
    wire halted = power_state.stop_mode | power_state.idle_level_one | power_state.warmup_active;
    wire wipe = power_state.hs_switch | power_state.standby_exit;
    // Saturates: only the shortest period matters here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            since_rst <= '0;
        end else if (!since_rst[16]) begin
            since_rst <= since_rst + 17'h1;
        end
    end
    property p_nmi; wd_expiry_irq |=> !wd_expiry_irq; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi pulse too long");
    property p_hw; hw_reset_req |=> hw_reset_req; endproperty
    a_hw: assert property (p_hw) else $error("reset request dropped");
    property p_halt; halted [*3] |-> !wd_expiry_irq; endproperty
    a_halt: assert property (p_halt) else $error("expiry while halted");
    property p_min; wd_expiry_irq || hw_reset_req |-> since_rst >= 17'h0FFF0; endproperty
    a_min: assert property (p_min) else $error("expiry too early");
    property p_wipe; wipe |=> !wd_expiry_irq [*8]; endproperty
    a_wipe: assert property (p_wipe) else $error("expiry after counter wipe");
    property p_rst; $rose(aresetn) |-> !wd_expiry_irq && !hw_reset_req; endproperty
    a_rst: assert property (p_rst) else $error("events out of reset");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response not held");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
endmodule : rdwdt_chk
bind rdwdt_top rdwdt_chk u_chk (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_state, .wd_expiry_irq, .hw_reset_req);

/* tb/rdwdt_cpu.sv */
`timescale 1ns/1ns
module rdwdt_cpu (
    // Clock
    input wire logic aclk,
    // From the watchdog
    input wire logic wd_expiry_irq,
    input wire logic hw_reset_req,
    // Taken events
    output int nmi_count = 0,
    output logic rst_seen = 1'b0
);
    // No mask on this path: every pulse is taken
    always @(posedge aclk) begin
        if (wd_expiry_irq === 1'b1) nmi_count <= nmi_count + 1;
        if (hw_reset_req === 1'b1) rst_seen <= 1'b1;
    end
endmodule : rdwdt_cpu

/* tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    import rdwdt_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic wd_expiry_irq, hw_reset_req, irq, rst_seen;
    rdwdt_power_t power_state = '0;
    int nmi_count, cyc, num_errors = 0, check_count = 0;
    logic [33:0] exp_q[$];
    logic [1:0] b_q[$];
    always #25 aclk = ~aclk;
    rdwdt_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .power_state, .wd_expiry_irq, .hw_reset_req, .irq);
    rdwdt_cpu u_cpu (.aclk, .wd_expiry_irq, .hw_reset_req, .nmi_count, .rst_seen);
    task test_done;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    task chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task chk_b(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t bresp %h exp %h", $time, got, exp);
        end
    endtask : chk_b
    task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RDWDT_RESP_OKAY);
        bit ap, wp;
        ap = 1'b1;
        wp = 1'b1;
        @(posedge aclk);
        b_q.push_back(r);
        s_axi_awaddr <= a;
        // Upper bits are noise the block must ignore
        s_axi_wdata <= {24'($urandom), d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (ap || wp) begin
            @(posedge aclk);
            ap = ap && (s_axi_awready !== 1'b1);
            wp = wp && (s_axi_wready !== 1'b1);
            s_axi_awvalid <= ap;
            s_axi_wvalid <= wp;
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        exp_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_q.size() > 0) begin
            chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && b_q.size() > 0) begin
            chk_b(s_axi_bresp, b_q.pop_front());
        end
    end
    initial begin
        void'($urandom(61));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(RDWDT_MODE_OFS, 34'h82);
        rd(RDWDT_COUNT_OFS, 34'h0);
        rd(8'h14, {RDWDT_RESP_SLVERR, 32'h0});
        wr(RDWDT_MASK_OFS, 8'h01);
        s_axi_wstrb <= 4'h0;
        wr(RDWDT_MASK_OFS, 8'hFE);
        s_axi_wstrb <= 4'hF;
        rd(RDWDT_MASK_OFS, 34'h01);
        wr(8'h14, 8'h55, RDWDT_RESP_SLVERR);
        wr(RDWDT_MODE_OFS, 8'h02);
        wr(RDWDT_MODE_OFS, 8'h82);
        rd(RDWDT_MODE_OFS, 34'h02);
        // Each halt kind once; wipes by key, standby exit and clock switch
        for (int i = 0; i < 3; i++) begin
            power_state <= '0;
            repeat ($urandom_range(20, 300)) @(posedge aclk);
            power_state <= rdwdt_power_t'((5'h10 >> i) | 5'(i));
            if (i == 0) wr(RDWDT_CLEAR_OFS, RDWDT_CLEAR_KEY);
            @(posedge aclk);
            power_state <= rdwdt_power_t'(5'h10 >> i);
            repeat ($urandom_range(5, 50)) @(posedge aclk);
            rd(RDWDT_COUNT_OFS, 34'h0);
        end
        rd(RDWDT_STATUS_OFS, 34'h02);
        power_state <= '0;
        cyc = 0;
        while (nmi_count == 0 && cyc < 70000) begin
            @(posedge aclk);
            cyc++;
        end
        chk({33'h0, cyc >= 65525 && cyc <= 65545}, 34'h1);
        chk({33'h0, irq}, 34'h1);
        chk({33'h0, rst_seen}, 34'h0);
        rd(RDWDT_STATUS_OFS, 34'h03);
        wr(RDWDT_STATUS_OFS, 8'h03);
        rd(RDWDT_STATUS_OFS, 34'h00);
        chk({33'h0, irq}, 34'h0);
        wr(RDWDT_MODE_OFS, 8'hE0);
        rd(RDWDT_MODE_OFS, 34'h60);
        wr(RDWDT_MODE_OFS, 8'h02);
        rd(RDWDT_MODE_OFS, 34'h00);
        rd(RDWDT_CLEAR_OFS, 34'h0);
        @(posedge aclk);
        chk(34'(exp_q.size() + b_q.size()), 34'h0);
        test_done();
    end
    initial begin
        #(90000 * 50);
        num_errors++;
        test_done();
    end
endmodule : tb_top
